// ==== dv/pwp_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------
// host side: one command at a time, bounded wait
// ------------------------------------------------
module pwp_host (
    // clock
    input  wire logic        clk_sys,
    // command port
    output var  logic        cmd_valid,
    output var  logic        cmd_write,
    output var  logic [7:0]  cmd_code,
    output var  logic [15:0] cmd_data,
    input  wire logic        cmd_done,
    input  wire logic        cmd_refused,
    input  wire logic [15:0] rd_data
);
    logic [15:0] rd;
    logic        rf;
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code  = 8'h00;
        cmd_data  = 16'h0000;
    end
    // callers keep pages to 0..7 or global, page set first
    task automatic xfer(input logic w, input logic [7:0] c,
                        input logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_data  = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (cmd_done !== 1'b1 && n < 8) begin
            @(negedge clk_sys);
            n++;
        end
        rd = rd_data;
        rf = cmd_refused;
        if (n == 8) begin
            tb.failures++;
            tb.wrap_up();
        end
    endtask
    // one write pulse, strobes and forwards are watched by the caller
    task automatic fire(input logic [7:0] c, input logic [15:0] d);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_code  = c;
        cmd_data  = d;
        @(negedge clk_sys);
        cmd_valid = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import pwp_pkg::*;;
    logic        clk_sys, reset, wp_pin, blk_next, log_we, meas_valid;
    logic [7:0]  log_addr, log_wdata, blk_data, restart_attempt_limit;
    logic [3:0]  meas_idx;
    logic [15:0] meas_word, cmd_data, rd_data;
    logic [7:0]  cmd_code, chan_op_we, chan_clear;
    logic        cmd_valid, cmd_write, cmd_done, cmd_refused, cml_fault;
    logic        blk_valid, blk_active, nv_restore, nv_erase;
    logic [17:0] seen;
    logic        log_lock_set, fwd_valid, fwd_write;
    logic [7:0]  chan_onoff_we, chan_cfg_data, fwd_code, fwd_chan;
    logic [15:0] fwd_data;
    int          failures, n_checks, k;
    pwp_core DUT (.clk_sys, .reset, .wp_pin, .cmd_valid, .cmd_write,
        .cmd_code, .cmd_data, .cmd_done, .cmd_refused, .rd_data,
        .cml_fault, .blk_next, .blk_valid, .blk_data, .blk_active,
        .log_we, .log_addr, .log_wdata, .log_lock_set,
        .nv_busy(1'b0), .nv_restore, .nv_erase, .meas_valid, .meas_idx,
        .meas_word, .shared_status(8'hA5), .chan_op_we,
        .chan_onoff_we, .chan_clear, .chan_cfg_data,
        .restart_attempt_limit, .fwd_valid, .fwd_write, .fwd_code,
        .fwd_data, .fwd_chan);
    pwp_host host (.clk_sys, .cmd_valid, .cmd_write, .cmd_code,
        .cmd_data, .cmd_done, .cmd_refused, .rd_data);
    always #25 clk_sys = ~clk_sys;
    // strobes are single cycle, so gather them between commands
    always @(posedge clk_sys) seen <= seen | {nv_restore, nv_erase,
        chan_clear, chan_op_we};
    task automatic chk(input string s, input logic [31:0] g, e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic go(input logic w, input logic [7:0] c,
                      input logic [15:0] d);
        seen = 18'h0;
        host.xfer(w, c, d);
    endtask
    task automatic meas(input logic [3:0] i, input logic [15:0] w);
        @(negedge clk_sys);
        {meas_valid, meas_idx, meas_word} = {1'b1, i, w};
        @(negedge clk_sys);
        meas_valid = 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        {clk_sys, reset, wp_pin, blk_next, log_we, meas_valid} = 6'b010000;
        {log_lock_set, log_addr, log_wdata, meas_idx, meas_word, seen} = '0;
        repeat (6) @(negedge clk_sys);
        reset = 1'b0;
        go(0, CMD_RETRY, 0);
        chk("retry", host.rd, 16'h0007);
        go(1, CMD_RETRY, 16'h0003);
        go(0, CMD_RETRY, 0);
        chk("retry", host.rd, 16'h0003);
        go(1, CMD_GMASK, 16'h0005);
        go(1, CMD_PAGE, 16'h00FF);
        go(1, CMD_OPERATION, 16'h0080);
        chk("gop", seen, 18'h5);
        go(0, CMD_VOUT_LOW, 0);
        chk("ffrd", {host.rf, cml_fault}, 2'b11);
        go(1, 8'hF8, 16'h0001);
        chk("ffwr", host.rf, 1'b1);
        go(1, CMD_CLEAR, 0);
        chk("gclr", {cml_fault, seen}, 19'h500);
        host.fire(CMD_ONOFF, 16'h001E);
        chk("gonoff", {chan_onoff_we, chan_cfg_data}, 16'h051E);
        go(1, CMD_PAGE, 16'h0003);
        go(1, CMD_OPERATION, 16'h0080);
        chk("op", seen, 18'h8);
        host.fire(8'h20, 16'h1234);
        chk("fwd", {fwd_valid, fwd_chan, fwd_code}, 17'h10820);
        chk("fwdw", {fwd_write, fwd_data}, 17'h11234);
        // level 1, level 2, then guard pin
        go(1, CMD_WRPROT, 16'h0080);
        go(1, CMD_RETRY, 16'h0009);
        chk("l1", host.rf, 1'b1);
        go(1, CMD_OPERATION, 16'h0080);
        chk("l1op", seen, 18'h0);
        go(0, CMD_RETRY, 0);
        chk("l1rd", {host.rf, host.rd}, 17'h3);
        go(1, CMD_WRPROT, 16'h0040);
        go(1, CMD_OPERATION, 16'h0080);
        chk("l2op", seen, 18'h8);
        go(1, CMD_RETRY, 16'h0009);
        chk("l2", host.rf, 1'b1);
        go(1, CMD_WRPROT, 16'h0000);
        wp_pin = 1'b1;
        repeat (4) @(negedge clk_sys);
        go(1, CMD_RETRY, 16'h0009);
        chk("pin", host.rf, 1'b1);
        go(1, CMD_WRPROT, 16'h0080);
        go(1, CMD_OPERATION, 16'h0080);
        chk("pinl1", seen, 18'h0);
        go(1, CMD_WRPROT, 16'h0000);
        wp_pin = 1'b0;
        repeat (4) @(negedge clk_sys);
        go(1, CMD_WRPROT, 16'h0022);
        chk("resv", host.rf, 1'b1);
        go(1, CMD_RETRY, 16'h0009);
        chk("open", restart_attempt_limit, 8'h09);
        go(0, CMD_SHARED, 0);
        chk("shared", host.rd, 16'h00A5);
        go(1, CMD_FR_LOAD, 0);
        chk("load", seen[17:16], 2'b10);
        log_lock_set = 1'b1;
        @(negedge clk_sys);
        log_lock_set = 1'b0;
        go(0, CMD_FR_STATE, 0);
        chk("lock", host.rd, 16'h0001);
        go(1, CMD_FR_ERASE, 0);
        chk("erase", seen[17:16], 2'b01);
        go(0, CMD_FR_STATE, 0);
        chk("unlock", host.rd, 16'h0000);
        meas(3, 16'h9800);
        meas(3, 16'h1000);
        meas(3, 16'h2000);
        go(0, CMD_VOUT_LOW, 0);
        chk("vout", host.rd, 16'h1000);
        meas(8, 16'h0014);
        meas(8, 16'hD280);
        go(0, CMD_VIN_LOW, 0);
        chk("vin", host.rd, 16'hD280);
        go(0, CMD_HEAT_LOW, 0);
        chk("heat0", host.rd, 16'hFFFF);
        meas(9, 16'h0820);
        meas(9, 16'hF840);
        go(0, CMD_HEAT_LOW, 0);
        chk("heat", host.rd, 16'hF840);
        for (int i = 0; i < 255; i++) begin
            @(negedge clk_sys);
            {log_we, log_addr, log_wdata} = {1'b1, i[7:0], i[7:0] ^ 8'h5A};
        end
        @(negedge clk_sys);
        log_we = 1'b0;
        go(0, CMD_FR_STREAM, 0);
        chk("head", host.rd, 16'h00FF);
        for (int i = 0; i < 255; i++) begin
            @(negedge clk_sys);
            blk_next = 1'b1;
            @(negedge clk_sys);
            blk_next = 1'b0;
            for (k = 0; blk_valid !== 1'b1 && k < 4; k++) @(negedge clk_sys);
            chk("byte", {k < 4, blk_data}, {1'b1, i[7:0] ^ 8'h5A});
            if (k == 4) wrap_up();
        end
        repeat (3) @(negedge clk_sys);
        chk("end", blk_active, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire

// ==== rtl/pwp_core.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwp_core import pwp_pkg::*; #(
    parameter int FR_DEPTH = 256
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // write guard pin
    input  wire logic        wp_pin,
    // decoded bus transactions
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_data,
    output logic             cmd_done,
    output logic             cmd_refused,
    output logic      [15:0] rd_data,
    output logic             cml_fault,
    // fault record block read
    input  wire logic        blk_next,
    output logic             blk_valid,
    output logic      [7:0]  blk_data,
    output logic             blk_active,
    // fault record store side
    input  wire logic        log_we,
    input  wire logic [7:0]  log_addr,
    input  wire logic [7:0]  log_wdata,
    input  wire logic        log_lock_set,
    input  wire logic        nv_busy,
    output logic             nv_restore,
    output logic             nv_erase,
    // measurements and shared status
    input  wire logic        meas_valid,
    input  wire logic [3:0]  meas_idx,
    input  wire logic [15:0] meas_word,
    input  wire logic [7:0]  shared_status,
    // channel strobes
    output logic      [7:0]  chan_op_we,
    output logic      [7:0]  chan_onoff_we,
    output logic      [7:0]  chan_clear,
    output logic      [7:0]  chan_cfg_data,
    output logic      [7:0]  restart_attempt_limit,
    // commands for the rest of the device
    output logic             fwd_valid,
    output logic             fwd_write,
    output logic      [7:0]  fwd_code,
    output logic      [15:0] fwd_data,
    output logic      [7:0]  fwd_chan
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  page_reg, gmask_reg, wp_reg, retry_reg;
    logic [2:0]  wp_sync_reg;
    logic        wp_level_reg, lock_reg, cml_reg;
    logic        s1_valid_reg, s1_ref_reg, s1_min_reg;
    logic [15:0] s1_word_reg;
    logic [3:0]  trk_idx;
    logic [15:0] trk_word;
    logic [7:0]  fr_idx_reg, mem_q;
    pwp_fr_e     fr_reg;
    logic        wr, rd, glob, prot1, prot2, l1_ok, l2_ok;
    logic        blocked, glob_ok, local_c, ro_c, wo_c, paged;
    logic        fwd_c, bad_wp, refuse, go, fr_rd;
    logic [7:0]  cmask;
    logic [15:0] rd_word;

    // ------------------------------------------------------------
    // guard pin: three flops, change taken when last two agree
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wp_sync_reg  <= 3'h0;
            wp_level_reg <= 1'b0;
        end else begin
            wp_sync_reg <= {wp_sync_reg[1:0], wp_pin};
            if (wp_sync_reg[1] == wp_sync_reg[2]) begin
                wp_level_reg <= wp_sync_reg[2];
            end
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    always_comb begin
        wr    = cmd_valid && cmd_write;
        rd    = cmd_valid && !cmd_write;
        glob  = page_reg == PAGE_GLOBAL;
        prot1 = wp_reg == WP_LEVEL1;
        prot2 = !prot1 && (wp_reg == WP_LEVEL2 || wp_level_reg);
        l1_ok = cmd_code inside {CMD_WRPROT, CMD_PAGE, CMD_STORE_ALL};
        l2_ok = l1_ok || cmd_code inside {CMD_OPERATION, CMD_GMASK,
                                          CMD_CLEAR};
        blocked = prot1 ? !l1_ok : (prot2 ? !l2_ok : 1'b0);
        glob_ok = cmd_code inside {CMD_CLEAR, CMD_OPERATION,
                                   CMD_ONOFF};
        ro_c  = cmd_code inside {CMD_FR_STATE, CMD_FR_STREAM, CMD_SHARED,
                                 CMD_VOUT_LOW, CMD_VIN_LOW, CMD_HEAT_LOW};
        wo_c  = cmd_code inside {CMD_CLEAR, CMD_FR_LOAD, CMD_FR_ERASE};
        local_c = ro_c || wo_c || glob_ok || cmd_code inside {CMD_PAGE,
                  CMD_WRPROT, CMD_GMASK, CMD_RETRY};
        fwd_c = !local_c || (rd && cmd_code inside {CMD_OPERATION,
                                                    CMD_ONOFF});
        paged = glob_ok || !local_c || cmd_code == CMD_VOUT_LOW;
        bad_wp = cmd_code == CMD_WRPROT && !(cmd_data[7:0] inside
                 {WP_LEVEL1, WP_LEVEL2, WP_NONE});
        refuse = (wr && (blocked
                 || (glob && paged && !glob_ok)
                 || ro_c || bad_wp))
              || (rd && ((glob && paged) || wo_c));
        go    = cmd_valid && !refuse;
        if (glob) begin
            cmask = gmask_reg;
        end else if (page_reg <= PAGE_LAST) begin
            cmask = 8'h01 << page_reg[2:0];
        end else begin
            cmask = 8'h00;
        end
        if (cmd_code == CMD_VOUT_LOW) begin
            trk_idx = {1'b0, page_reg[2:0]};
        end else if (cmd_code == CMD_VIN_LOW) begin
            trk_idx = TRK_VIN;
        end else begin
            trk_idx = TRK_HEAT;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            page_reg  <= PAGE_RST;
            gmask_reg <= GMASK_RST;
            wp_reg    <= WP_RST;
            retry_reg <= RETRY_RST;
        end else if (go && cmd_write) begin
            case (cmd_code)
                CMD_PAGE:   page_reg  <= cmd_data[7:0];
                CMD_GMASK:  gmask_reg <= cmd_data[7:0];
                CMD_WRPROT: wp_reg    <= cmd_data[7:0];
                CMD_RETRY:  retry_reg <= cmd_data[7:0];
                default:    page_reg  <= page_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // fault flag and record lock; a set beats a same-cycle clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cml_reg <= 1'b0;
        end else if (cmd_valid && refuse) begin
            cml_reg <= 1'b1;
        end else if (go && cmd_write && cmd_code == CMD_CLEAR) begin
            cml_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lock_reg <= 1'b0;
        end else if (log_lock_set) begin
            lock_reg <= 1'b1;
        end else if (go && cmd_write && cmd_code == CMD_FR_ERASE) begin
            lock_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // strobes to channels and to the record store
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            chan_op_we    <= 8'h00;
            chan_onoff_we <= 8'h00;
            chan_clear    <= 8'h00;
            chan_cfg_data <= 8'h00;
            nv_restore    <= 1'b0;
            nv_erase      <= 1'b0;
        end else begin
            chan_op_we    <= (go && wr && cmd_code == CMD_OPERATION)
                             ? cmask : 8'h00;
            chan_onoff_we <= (go && wr && cmd_code == CMD_ONOFF)
                             ? cmask : 8'h00;
            chan_clear    <= (go && wr && cmd_code == CMD_CLEAR)
                             ? cmask : 8'h00;
            chan_cfg_data <= cmd_data[7:0];
            nv_restore    <= go && wr && cmd_code == CMD_FR_LOAD;
            nv_erase      <= go && wr && cmd_code == CMD_FR_ERASE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fwd_valid <= 1'b0;
            fwd_write <= 1'b0;
            fwd_code  <= 8'h00;
            fwd_data  <= 16'h0000;
            fwd_chan  <= 8'h00;
        end else begin
            fwd_valid <= go && fwd_c;
            fwd_write <= cmd_write;
            fwd_code  <= cmd_code;
            fwd_data  <= cmd_data;
            fwd_chan  <= cmask;
        end
    end

    // ------------------------------------------------------------
    // local read answers, two cycles after the request
    // ------------------------------------------------------------
    always_comb begin
        case (cmd_code)
            CMD_PAGE:      rd_word = {8'h00, page_reg};
            CMD_WRPROT:    rd_word = {8'h00, wp_reg};
            CMD_GMASK:     rd_word = {8'h00, gmask_reg};
            CMD_RETRY:     rd_word = {8'h00, retry_reg};
            CMD_FR_STATE:  rd_word = {14'h0000, nv_busy, lock_reg};
            CMD_FR_STREAM: rd_word = {8'h00, FR_HEAD};
            CMD_SHARED:    rd_word = {8'h00, shared_status};
            default:       rd_word = WORD_UNDEF;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            s1_valid_reg <= 1'b0;
            s1_ref_reg   <= 1'b0;
            s1_min_reg   <= 1'b0;
            s1_word_reg  <= 16'h0000;
            cmd_done     <= 1'b0;
            cmd_refused  <= 1'b0;
            rd_data      <= 16'h0000;
        end else begin
            s1_valid_reg <= cmd_valid && (!fwd_c || refuse);
            s1_ref_reg   <= refuse;
            s1_min_reg   <= !refuse && cmd_code inside {CMD_VOUT_LOW,
                            CMD_VIN_LOW, CMD_HEAT_LOW};
            s1_word_reg  <= refuse ? WORD_UNDEF : rd_word;
            cmd_done     <= s1_valid_reg;
            cmd_refused  <= s1_valid_reg && s1_ref_reg;
            if (s1_valid_reg) begin
                rd_data <= s1_min_reg ? trk_word : s1_word_reg;
            end
        end
    end

    // ------------------------------------------------------------
    // fault record stream: head byte, then 255 from RAM
    // ------------------------------------------------------------
    assign fr_rd = fr_reg == FR_ARMED && blk_next;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            fr_reg     <= FR_IDLE;
            fr_idx_reg <= 8'h00;
            blk_valid  <= 1'b0;
            blk_data   <= 8'h00;
        end else begin
            blk_valid <= 1'b0;
            if (go && rd && cmd_code == CMD_FR_STREAM) begin
                fr_reg     <= FR_ARMED;
                fr_idx_reg <= 8'h00;
            end else begin
                case (fr_reg)
                    FR_ARMED: if (blk_next) begin
                        fr_reg <= FR_FETCH;
                    end
                    FR_FETCH: begin
                        blk_valid  <= 1'b1;
                        blk_data   <= mem_q;
                        fr_idx_reg <= fr_idx_reg + 8'h01;
                        fr_reg <= (fr_idx_reg == FR_LAST) ? FR_IDLE
                                                          : FR_ARMED;
                    end
                    default: fr_reg <= FR_IDLE;
                endcase
            end
        end
    end
    assign blk_active            = fr_reg != FR_IDLE;
    assign cml_fault             = cml_reg;
    assign restart_attempt_limit = retry_reg;

    pwp_frmem #(.DEPTH(FR_DEPTH), .AW(8)) u_frmem (
        .clk_sys (clk_sys),
        .reset   (reset),
        .we      (log_we),
        .waddr   (log_addr),
        .wdata   (log_wdata),
        .re      (fr_rd),
        .raddr   (fr_idx_reg),
        .rdata   (mem_q)
    );

    pwp_mintrk #(.N(10), .N_L16(8)) u_mintrk (
        .clk_sys    (clk_sys),
        .reset      (reset),
        .meas_valid (meas_valid),
        .meas_idx   (meas_idx),
        .meas_word  (meas_word),
        .rd_idx     (trk_idx),
        .rd_word    (trk_word)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_page_route;
        wr && !prot1 && page_reg <= PAGE_LAST
        && cmd_code == CMD_OPERATION
        |=> chan_op_we == (8'h01 << $past(page_reg[2:0]));
    endproperty
    a_page_route: assert property (p_page_route)
        else $error("single page did not hit its channel");
    property p_glob_mask;
        wr && !prot1 && glob && cmd_code == CMD_CLEAR
        |=> chan_clear == $past(gmask_reg) && !cml_fault;
    endproperty
    a_glob_mask: assert property (p_glob_mask)
        else $error("global clear missed masked channels");
    property p_glob_bad_wr;
        wr && glob && cmd_code == CMD_RETRY + 8'h01
        |=> !fwd_valid && cml_fault ##1 cmd_done && cmd_refused;
    endproperty
    a_glob_bad_wr: assert property (p_glob_bad_wr)
        else $error("global write to paged command not refused");
    property p_glob_rd;
        rd && glob && cmd_code == CMD_VOUT_LOW
        |=> cml_fault ##1 cmd_done && rd_data == WORD_UNDEF;
    endproperty
    a_glob_rd: assert property (p_glob_rd)
        else $error("global paged read not faulted");
    property p_level1;
        wr && wp_reg == WP_LEVEL1 && cmd_code == CMD_OPERATION
        |=> chan_op_we == 8'h00 && cml_fault;
    endproperty
    a_level1: assert property (p_level1)
        else $error("level 1 let a channel write through");
    property p_pin_level2;
        wr && wp_level_reg && wp_reg == WP_NONE && cmd_code == CMD_RETRY
        |=> $stable(retry_reg) ##1 cmd_refused;
    endproperty
    a_pin_level2: assert property (p_pin_level2)
        else $error("guard pin did not block write");
    property p_read_ok;
        rd && wp_reg == WP_LEVEL1 && cmd_code == CMD_RETRY
        |=> ##1 cmd_done && !cmd_refused
        && rd_data[7:0] == $past(retry_reg, 2);
    endproperty
    a_read_ok: assert property (p_read_ok)
        else $error("read refused under protection");
    property p_stream;
        rd && cmd_code == CMD_FR_STREAM
        |=> blk_active ##1 rd_data == 16'h00FF;
    endproperty
    a_stream: assert property (p_stream)
        else $error("record read did not start with head byte");
    property p_restore;
        wr && !prot1 && !prot2 && cmd_code == CMD_FR_LOAD |=> nv_restore;
    endproperty
    a_restore: assert property (p_restore)
        else $error("restore strobe missing");
    c_glob_op: cover property (wr && glob && cmd_code == CMD_OPERATION);
    c_blocked: cover property (cmd_refused ##1 !cml_fault);
    c_blk_end: cover property (blk_valid && !blk_active);
endmodule
`default_nettype wire

// ==== rtl/pwp_frmem.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwp_frmem #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          clk_sys,
    input  wire logic          reset,
    // write side
    input  wire logic          we,
    input  wire logic [AW-1:0] waddr,
    input  wire logic [7:0]    wdata,
    // read side
    input  wire logic          re,
    input  wire logic [AW-1:0] raddr,
    output logic      [7:0]    rdata
);
    logic [7:0] mem [DEPTH];

    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata <= 8'h00;
        end else if (re) begin
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

// ==== rtl/pwp_mintrk.sv ====
`timescale 1ns/1ps
`default_nettype none
module pwp_mintrk import pwp_pkg::*; #(
    parameter int N     = 10,
    parameter int N_L16 = 8
) (
    // clock
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // samples
    input  wire logic        meas_valid,
    input  wire logic [3:0]  meas_idx,
    input  wire logic [15:0] meas_word,
    // read
    input  wire logic [3:0]  rd_idx,
    output logic      [15:0] rd_word
);
    logic [15:0] low_w  [N];
    logic [N-1:0] seen_w;

    generate
        for (genvar i = 0; i < N; i++) begin : g_ch
            logic [15:0] low_reg;
            logic        seen_reg;
            logic        lower;
            always_comb begin
                if (i < N_L16) begin
                    lower = meas_word < low_reg;
                end else begin
                    lower = pwp_l11_fixed(meas_word)
                          < pwp_l11_fixed(low_reg);
                end
            end
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    low_reg  <= WORD_UNDEF;
                    seen_reg <= 1'b0;
                end else if (meas_valid && meas_idx == 4'(i)
                             && (!seen_reg || lower)) begin
                    low_reg  <= meas_word;
                    seen_reg <= 1'b1;
                end
            end
            assign low_w[i]  = low_reg;
            assign seen_w[i] = seen_reg;
        end
    endgenerate

    // unsampled entries read as all ones
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rd_word <= WORD_UNDEF;
        end else if (rd_idx < 4'(N) && seen_w[rd_idx]) begin
            rd_word <= low_w[rd_idx];
        end else begin
            rd_word <= WORD_UNDEF;
        end
    end
endmodule
`default_nettype wire

// ==== rtl/pwp_pkg.sv ====
// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
package pwp_pkg;
    localparam logic [7:0] CMD_PAGE      = 8'h00;
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ONOFF     = 8'h02;
    localparam logic [7:0] CMD_CLEAR     = 8'h03;
    localparam logic [7:0] CMD_WRPROT    = 8'h10;
    localparam logic [7:0] CMD_STORE_ALL = 8'h15;
    localparam logic [7:0] CMD_GMASK     = 8'hE4;
    localparam logic [7:0] CMD_FR_LOAD   = 8'hEB;
    localparam logic [7:0] CMD_FR_ERASE  = 8'hEC;
    localparam logic [7:0] CMD_FR_STATE  = 8'hED;
    localparam logic [7:0] CMD_FR_STREAM = 8'hEE;
    localparam logic [7:0] CMD_SHARED    = 8'hEF;
    localparam logic [7:0] CMD_RETRY     = 8'hF7;
    localparam logic [7:0] CMD_VOUT_LOW  = 8'hFB;
    localparam logic [7:0] CMD_VIN_LOW   = 8'hFC;
    localparam logic [7:0] CMD_HEAT_LOW  = 8'hFD;

    // ------------------------------------------------------------
    // values, resets, fields
    // ------------------------------------------------------------
    localparam logic [7:0]  PAGE_GLOBAL = 8'hFF;
    localparam logic [7:0]  PAGE_LAST   = 8'h07;
    localparam logic [7:0]  WP_LEVEL1   = 8'h80;
    localparam logic [7:0]  WP_LEVEL2   = 8'h40;
    localparam logic [7:0]  WP_NONE     = 8'h00;
    localparam logic [7:0]  PAGE_RST    = 8'h00;
    localparam logic [7:0]  GMASK_RST   = 8'hFF;
    localparam logic [7:0]  RETRY_RST   = 8'h07;
    localparam logic [7:0]  WP_RST      = 8'h00;
    localparam logic [7:0]  FR_HEAD     = 8'hFF;
    localparam logic [7:0]  FR_LAST     = 8'hFE;
    localparam logic [15:0] WORD_UNDEF  = 16'hFFFF;
    localparam logic [3:0]  TRK_VIN     = 4'h8;
    localparam logic [3:0]  TRK_HEAT    = 4'h9;
    localparam int          L11_EXP_LSB = 11;
    localparam int          L11_MANT_W  = 11;
    localparam int          L16_EXP     = -13;
    localparam logic [4:0]  L11_BIAS    = 5'h10;

    typedef enum logic [1:0] {
        FR_IDLE  = 2'b00,
        FR_ARMED = 2'b01,
        FR_FETCH = 2'b10
    } pwp_fr_e;

    // value times 2^16, so exponents -16..15 become shifts 0..31
    function automatic logic signed [47:0] pwp_l11_fixed(
        input logic [15:0] w);
        logic signed [47:0] m;
        logic [4:0]         sh;
        m  = 48'(signed'(w[L11_MANT_W-1:0]));
        sh = 5'(w[15:L11_EXP_LSB] + L11_BIAS);
        return m <<< sh;
    endfunction
endpackage
